// ---- rtl/charger_regs_pkg.sv ----
// Register map, field layout, reset values and timing counts of the charger register bank.
package charger_regs_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h3F;
  localparam logic [7:0] ADDR_RECHG = 8'h04;
  localparam logic [7:0] ADDR_VBREG = 8'h05;
  localparam logic [7:0] ADDR_SYSFL = 8'h06;
  localparam logic [7:0] ADDR_TIMERS = 8'h07;
  localparam logic [7:0] ADDR_BSWITCH = 8'h08;
  localparam logic [7:0] ADDR_CONV = 8'h09;
  localparam logic [7:0] ADDR_SRCDET = 8'h0A;
  localparam logic [7:0] ADDR_PROT = 8'h0C;
  localparam logic [7:0] ADDR_NTCACT = 8'h0D;
  localparam logic [7:0] ADDR_NTCTH = 8'h0E;
  localparam logic [7:0] ADDR_IMPD = 8'h0F;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_STAT0 = 8'h11;
  localparam logic [7:0] RST_RECHG = 8'h16;
  localparam logic [7:0] RST_VBREG = 8'h18;
  localparam logic [7:0] RST_SYSFL = 8'h24;
  localparam logic [7:0] RST_TIMERS = 8'h1E;
  localparam logic [7:0] RST_BSWITCH = 8'h7F;
  localparam logic [7:0] RST_CONV = 8'h53;
  localparam logic [7:0] RST_SRCDET = 8'h23;
  localparam logic [7:0] RST_PROT = 8'h11;
  localparam logic [7:0] RST_NTCACT = 8'h60;
  localparam logic [7:0] RST_NTCTH = 8'h99;
  localparam logic [7:0] RST_IMPD = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h44;
  // Writable bits per register; the rest are reserved and keep their reset value.
  localparam logic [7:0] WM_SYSFL = 8'h3F;
  localparam logic [7:0] WM_CONV = 8'h77;
  localparam logic [7:0] WM_SRCDET = 8'h33;
  localparam logic [7:0] WM_PROT = 8'h7F;
  localparam logic [7:0] WM_IMPD = 8'h7F;
  localparam logic [7:0] WM_MASK = 8'h3F;
  localparam logic [5:0] VBREG_MAX = 6'h28;
  localparam int VBREG_LSB = 0;
  localparam int RESTART_BIT = 6;
  localparam int SWOFF_BIT = 7;
  localparam int SWDLY_BIT = 6;
  localparam int FORCE_BIT = 4;
  localparam int LOWSTOP_BIT = 1;
  localparam int CLK_HZ = 25000000;
  localparam int SYNC_STAGES = 2;
  localparam int SCL_FILTER = 3;
endpackage

// ---- rtl/charger_config_register_bank.sv ----
// Two-wire slave register bank of a single-cell charger with its decoded controls.
`timescale 1ns/1ps
module charger_config_register_bank
  import charger_regs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Analog side status
  input wire logic input_good,
  input wire logic holdoff_done,
  input wire logic battery_low_cmp,
  input wire logic [3:0] port_detect_result,
  input wire logic charge_param_lock,
  input wire logic debounce_tick,
  input wire logic long_tick,
  // Decoded controls
  output logic start_port_detect_r,
  output logic battery_switch_open_r,
  output logic boost_lowbat_latched_r,
  output logic battery_low_pulse_r,
  output logic timeout_restart_r,
  output logic typec_sink_en_r,
  output logic typec_hiz_r,
  output logic test_source_en_r,
  output logic [7:0] rechg_out_r,
  output logic [7:0] vbreg_out_r,
  output logic [7:0] sysfl_out_r,
  output logic [7:0] bswitch_out_r,
  output logic [7:0] ntcact_out_r,
  output logic [7:0] ntcth_out_r,
  output logic [7:0] impd_out_r
);
  typedef enum logic [2:0] {IDLE, ADDR, REG, WDATA, RDATA, ACK, RACK} bus_state_t;
  logic [SYNC_STAGES-1:0] scl_s, sda_s, vg_s, hd_s, bl_s;
  logic scl_d, sda_d;
  logic [7:0] rechg_r, vbreg_r, sysfl_r, timers_r, bswitch_r, conv_r, srcdet_r;
  logic [7:0] prot_r, ntcact_r, ntcth_r, impd_r, mask_r;
  bus_state_t st_r, ret_r;
  logic [7:0] sh_r, ptr_r;
  logic [3:0] bit_r;
  logic ack_ok_r, wr_stb;
  logic [7:0] rdat;
  logic [3:0] swdly_r;
  logic [1:0] deb_r;
  logic auto_done_r;
  // Pins come from outside the clock domain.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_s <= '1;
      sda_s <= '1;
      vg_s <= '0;
      hd_s <= '0;
      bl_s <= '0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      vg_s <= {vg_s[0], input_good};
      hd_s <= {hd_s[0], holdoff_done};
      bl_s <= {bl_s[0], battery_low_cmp};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire bus_stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  // Read mux; status byte carries the detection result in its top nibble.
  always_comb
  begin
    unique case (ptr_r)
      ADDR_RECHG: rdat = rechg_r;
      ADDR_VBREG: rdat = vbreg_r;
      ADDR_SYSFL: rdat = sysfl_r;
      ADDR_TIMERS: rdat = timers_r;
      ADDR_BSWITCH: rdat = bswitch_r;
      ADDR_CONV: rdat = conv_r;
      ADDR_SRCDET: rdat = srcdet_r;
      ADDR_PROT: rdat = prot_r;
      ADDR_NTCACT: rdat = ntcact_r;
      ADDR_NTCTH: rdat = ntcth_r;
      ADDR_IMPD: rdat = impd_r;
      ADDR_MASK: rdat = mask_r;
      ADDR_STAT0: rdat = {port_detect_result, 4'h0};
      default: rdat = 8'h00;
    endcase
  end
  // Slave engine: address, pointer byte, then data with auto increment.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= IDLE;
      ret_r <= IDLE;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      bit_r <= 4'h0;
      ack_ok_r <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (bus_stop)
    begin
      st_r <= IDLE;
      sda_oe_n <= 1'b1;
    end
    else if (bus_start)
    begin
      st_r <= ADDR;
      bit_r <= 4'h0;
      sda_oe_n <= 1'b1;
    end
    else if (scl_rise && (st_r == ADDR || st_r == REG || st_r == WDATA))
    begin
      sh_r <= {sh_r[6:0], sda_s[1]};
      bit_r <= bit_r + 4'h1;
    end
    else if (scl_rise && st_r == RACK)
      ack_ok_r <= ~sda_s[1];
    else if (scl_fall)
    begin
      unique case (st_r)
        IDLE: sda_oe_n <= 1'b1;
        ADDR, REG, WDATA:
        begin
          if (bit_r == 4'h8)
          begin
            bit_r <= 4'h0;
            if (st_r == ADDR)
            begin
              if (sh_r[7:1] == DEV_ADDR)
              begin
                sda_oe_n <= 1'b0;
                ret_r <= sh_r[0] ? RDATA : REG;
                st_r <= ACK;
              end
              else
                st_r <= IDLE;
            end
            else
            begin
              ptr_r <= (st_r == REG) ? sh_r : ptr_r + 8'h01;
              sda_oe_n <= 1'b0;
              ret_r <= WDATA;
              st_r <= ACK;
            end
          end
        end
        ACK:
        begin
          if (ret_r == RDATA)
          begin
            sh_r <= {rdat[6:0], 1'b0};
            sda_oe_n <= rdat[7];
            bit_r <= 4'h1;
          end
          else
            sda_oe_n <= 1'b1;
          st_r <= ret_r;
        end
        RDATA:
        begin
          if (bit_r == 4'h8)
          begin
            sda_oe_n <= 1'b1;
            ptr_r <= ptr_r + 8'h01;
            st_r <= RACK;
          end
          else
          begin
            sda_oe_n <= sh_r[7];
            sh_r <= {sh_r[6:0], 1'b0};
            bit_r <= bit_r + 4'h1;
          end
        end
        RACK:
        begin
          if (ack_ok_r)
          begin
            sh_r <= {rdat[6:0], 1'b0};
            sda_oe_n <= rdat[7];
            bit_r <= 4'h1;
            st_r <= RDATA;
          end
          else
            st_r <= IDLE;
        end
        default: st_r <= IDLE;
      endcase
    end
  end
  // A data byte is committed as its eighth clock falls, just as the acknowledge begins.
  assign wr_stb = scl_fall && st_r == WDATA && bit_r == 4'h8;
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] wm, input logic [7:0] lk);
    logic [7:0] m;
    m = (old & ~wm) | (nw & wm);
    // Locked fields accept a new value only when it does not rise.
    if (charge_param_lock && ((m & lk) > (old & lk)))
      m = (m & ~lk) | (old & lk);
    return m;
  endfunction
  // Register writes; fields decoded in the blocks below.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rechg_r <= RST_RECHG;
      vbreg_r <= RST_VBREG;
      sysfl_r <= RST_SYSFL;
      timers_r <= RST_TIMERS;
      bswitch_r <= RST_BSWITCH;
      conv_r <= RST_CONV;
      srcdet_r <= RST_SRCDET;
      prot_r <= RST_PROT;
      ntcact_r <= RST_NTCACT;
      ntcth_r <= RST_NTCTH;
      impd_r <= RST_IMPD;
      mask_r <= RST_MASK;
    end
    else
    begin
      // One-shot bits self-clear the cycle after they are written, whether or not they act.
      timers_r[RESTART_BIT] <= 1'b0;
      srcdet_r[FORCE_BIT] <= 1'b0;
      if (wr_stb)
      begin
        unique case (ptr_r)
          ADDR_RECHG: rechg_r <= sh_r;
          ADDR_VBREG: vbreg_r <= merge(vbreg_r, (sh_r[5:0] > VBREG_MAX) ?
                                       {sh_r[7:6], VBREG_MAX} : sh_r, 8'hFF, 8'h3F);
          ADDR_SYSFL: sysfl_r <= merge(sysfl_r, sh_r, WM_SYSFL, 8'h00);
          ADDR_TIMERS: timers_r <= sh_r;
          ADDR_BSWITCH: bswitch_r <= sh_r;
          ADDR_CONV: conv_r <= merge(conv_r, sh_r, WM_CONV, 8'h00);
          ADDR_SRCDET: srcdet_r <= merge(srcdet_r, sh_r, WM_SRCDET, 8'h00);
          ADDR_PROT: prot_r <= merge(prot_r, sh_r, WM_PROT, 8'h00);
          ADDR_NTCACT: ntcact_r <= merge(ntcact_r, sh_r, 8'hFF, 8'h0F);
          ADDR_NTCTH: ntcth_r <= sh_r;
          ADDR_IMPD: impd_r <= merge(impd_r, sh_r, WM_IMPD, 8'h00);
          ADDR_MASK: mask_r <= merge(mask_r, sh_r, WM_MASK, 8'h00);
          default: ;
        endcase
      end
    end
  end
  // Port detection start, battery switch delay and battery-low handling.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      start_port_detect_r <= 1'b0;
      auto_done_r <= 1'b0;
      battery_switch_open_r <= 1'b0;
      swdly_r <= 4'h0;
      deb_r <= 2'b00;
      battery_low_pulse_r <= 1'b0;
      boost_lowbat_latched_r <= 1'b0;
    end
    else
    begin
      start_port_detect_r <= 1'b0;
      if (!vg_s[1])
        auto_done_r <= 1'b0;
      else if (srcdet_r[5] && hd_s[1] && !auto_done_r)
      begin
        start_port_detect_r <= 1'b1;
        auto_done_r <= 1'b1;
      end
      if (srcdet_r[FORCE_BIT] && vg_s[1])
        start_port_detect_r <= 1'b1;
      // Ten ticks of the one-second tick make the delayed opening.
      if (!bswitch_r[SWOFF_BIT])
      begin
        swdly_r <= 4'h0;
        battery_switch_open_r <= 1'b0;
      end
      else if (!bswitch_r[SWDLY_BIT] || swdly_r == 4'hA)
        battery_switch_open_r <= 1'b1;
      else if (long_tick)
        swdly_r <= swdly_r + 4'h1;
      // Debounce ticks every 5 ms; two ticks low give the 10 ms filter.
      battery_low_pulse_r <= 1'b0;
      if (!bl_s[1])
        deb_r <= 2'b00;
      else if (debounce_tick && deb_r != 2'b11)
      begin
        deb_r <= deb_r + 2'b01;
        if (deb_r == 2'b01)
        begin
          battery_low_pulse_r <= ~mask_r[1];
          if (prot_r[LOWSTOP_BIT])
            boost_lowbat_latched_r <= 1'b1;
        end
      end
      if (!conv_r[2])
        boost_lowbat_latched_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      timeout_restart_r <= 1'b0;
      typec_sink_en_r <= 1'b0;
      typec_hiz_r <= 1'b1;
      test_source_en_r <= 1'b0;
      rechg_out_r <= RST_RECHG;
      vbreg_out_r <= RST_VBREG;
      sysfl_out_r <= RST_SYSFL;
      bswitch_out_r <= RST_BSWITCH;
      ntcact_out_r <= RST_NTCACT;
      ntcth_out_r <= RST_NTCTH;
      impd_out_r <= RST_IMPD;
    end
    else
    begin
      timeout_restart_r <= timers_r[RESTART_BIT];
      typec_hiz_r <= (srcdet_r[1:0] == 2'b11);
      typec_sink_en_r <= (srcdet_r[1:0] == 2'b00) && (conv_r[6:4] == 3'b000);
      test_source_en_r <= impd_r[6];
      rechg_out_r <= rechg_r;
      vbreg_out_r <= vbreg_r;
      sysfl_out_r <= sysfl_r;
      bswitch_out_r <= bswitch_r;
      ntcact_out_r <= ntcact_r;
      ntcth_out_r <= ntcth_r;
      impd_out_r <= impd_r;
    end
  end
endmodule

// ---- dv/charger_config_register_bank_chk.sv ----
// Port-level checks of the charger register bank.
`timescale 1ns/1ps
module charger_config_register_bank_chk
  import charger_regs_pkg::*;
(
  // Clock, reset and analog side
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic input_good,
  input wire logic charge_param_lock,
  // Decoded controls
  input wire logic start_port_detect_r,
  input wire logic battery_switch_open_r,
  input wire logic battery_low_pulse_r,
  input wire logic typec_sink_en_r,
  input wire logic typec_hiz_r,
  input wire logic test_source_en_r,
  input wire logic [7:0] vbreg_out_r,
  input wire logic [7:0] sysfl_out_r,
  input wire logic [7:0] bswitch_out_r,
  input wire logic [7:0] impd_out_r
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_clamp;
    vbreg_out_r[5:0] <= VBREG_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("regulation code above clamp");
  property p_reserved;
    sysfl_out_r[7:6] == 2'h0 && impd_out_r[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit changed");
  property p_test_src;
    impd_out_r[6] [*3] |-> test_source_en_r;
  endproperty
  a_test_src: assert property (p_test_src) else $error("test source not on");
  property p_det_pulse;
    start_port_detect_r |=> !start_port_detect_r;
  endproperty
  a_det_pulse: assert property (p_det_pulse) else $error("detect start too long");
  property p_det_src;
    !input_good [*6] |-> !start_port_detect_r;
  endproperty
  a_det_src: assert property (p_det_src) else $error("detect without source");
  property p_low_pulse;
    battery_low_pulse_r |=> !battery_low_pulse_r;
  endproperty
  a_low_pulse: assert property (p_low_pulse) else $error("low pulse too long");
  property p_switch;
    $rose(battery_switch_open_r) |-> ##[0:2] bswitch_out_r[7];
  endproperty
  a_switch: assert property (p_switch) else $error("switch opened unasked");
  property p_pins;
    typec_hiz_r |-> !typec_sink_en_r;
  endproperty
  a_pins: assert property (p_pins) else $error("sink while high impedance");
  property p_lock;
    charge_param_lock [*3] |-> vbreg_out_r[5:0] <= $past(vbreg_out_r[5:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked code raised");
endmodule
bind charger_config_register_bank charger_config_register_bank_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .input_good(input_good),
  .charge_param_lock(charge_param_lock), .start_port_detect_r(start_port_detect_r),
  .battery_switch_open_r(battery_switch_open_r), .battery_low_pulse_r(battery_low_pulse_r),
  .typec_sink_en_r(typec_sink_en_r), .typec_hiz_r(typec_hiz_r),
  .test_source_en_r(test_source_en_r), .vbreg_out_r(vbreg_out_r),
  .sysfl_out_r(sysfl_out_r), .bswitch_out_r(bswitch_out_r), .impd_out_r(impd_out_r)
);

// ---- dv/charger_host_model.sv ----
// Two-wire bus host that frames start, stop and byte transfers.
`timescale 1ns/1ps
module charger_host_model #(
  parameter int QUARTER = 8
) (
  // Clock
  input wire logic sys_clk,
  // Bus lines; a released data line floats to the pull-up
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel
);
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic q();
    repeat (QUARTER) @(posedge sys_clk);
    #1;
  endtask
  // Data moves only while the clock line is low, so no false start or stop is seen.
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    s = sda_in;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic start();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], nack);
    bit_io(1'b1, nack);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask
endmodule

// ---- dv/charger_config_register_bank_tb.sv ----
// Bench of the charger register bank driven through the two-wire host model.
`timescale 1ns/1ps
module charger_config_register_bank_tb;
  import charger_regs_pkg::*;
  logic sys_clk, rst, input_good, holdoff_done, battery_low_cmp, charge_param_lock;
  logic debounce_tick, long_tick, scl, sda_rel, sda_out, sda_oe_n, sda_line, nack;
  logic start_port_detect_r, battery_switch_open_r, boost_lowbat_latched_r, battery_low_pulse_r;
  logic timeout_restart_r, typec_sink_en_r, typec_hiz_r, test_source_en_r;
  logic [3:0] port_detect_result;
  logic [7:0] rdat, rechg_out_r, sysfl_out_r, ntcact_out_r, ntcth_out_r;
  int mismatches = 0, n_tests = 0, n_det = 0, n_low = 0, n_rst = 0;
  logic [7:0] ra [14] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D,
    8'h0E, 8'h0F, 8'h10, 8'h0B, 8'h11};
  logic [7:0] rv [14] = '{8'h16, 8'h18, 8'h24, 8'h1E, 8'h7F, 8'h53, 8'h23, 8'h11, 8'h60,
    8'h99, 8'h00, 8'h44, 8'h00, 8'hE0};
  logic [7:0] wa [11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
    8'h10, 8'h0B};
  logic [7:0] wd [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'hFF, 8'hFF, 8'h00, 8'hFF,
    8'hFD, 8'hFF};
  logic [7:0] we [11] = '{8'hFF, 8'hE8, 8'h3F, 8'hBF, 8'h73, 8'h7F, 8'hFF, 8'h00, 8'h7F,
    8'h7D, 8'h00};
  assign sda_line = (sda_oe_n ? 1'b1 : sda_out) & sda_rel;
  charger_config_register_bank u_charger_config_register_bank (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .input_good(input_good), .holdoff_done(holdoff_done),
    .battery_low_cmp(battery_low_cmp), .port_detect_result(port_detect_result),
    .charge_param_lock(charge_param_lock), .debounce_tick(debounce_tick),
    .long_tick(long_tick), .start_port_detect_r(start_port_detect_r),
    .battery_switch_open_r(battery_switch_open_r),
    .boost_lowbat_latched_r(boost_lowbat_latched_r),
    .battery_low_pulse_r(battery_low_pulse_r), .timeout_restart_r(timeout_restart_r),
    .typec_sink_en_r(typec_sink_en_r), .typec_hiz_r(typec_hiz_r),
    .test_source_en_r(test_source_en_r), .rechg_out_r(rechg_out_r), .vbreg_out_r(),
    .sysfl_out_r(sysfl_out_r), .bswitch_out_r(), .ntcact_out_r(ntcact_out_r),
    .ntcth_out_r(ntcth_out_r), .impd_out_r()
  );
  charger_host_model u_charger_host_model (
    .sys_clk(sys_clk), .sda_in(sda_line), .scl(scl), .sda_rel(sda_rel)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (start_port_detect_r === 1'b1) n_det++;
    if (battery_low_pulse_r === 1'b1) n_low++;
    if (timeout_restart_r === 1'b1) n_rst++;
  end
  task wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
    u_charger_host_model.start();
    u_charger_host_model.put_byte({dev, 1'b0}, nack);
    if (nack === 1'b0)
    begin
      u_charger_host_model.put_byte(a, rdat[0]);
      u_charger_host_model.put_byte(d, rdat[0]);
    end
    u_charger_host_model.stop();
  endtask
  task rd(input logic [7:0] a);
    u_charger_host_model.start();
    u_charger_host_model.put_byte({DEV_ADDR, 1'b0}, nack);
    u_charger_host_model.put_byte(a, nack);
    u_charger_host_model.start();
    u_charger_host_model.put_byte({DEV_ADDR, 1'b1}, nack);
    u_charger_host_model.get_byte(1'b1, rdat);
    u_charger_host_model.stop();
  endtask
  task tick(input logic long_one);
    debounce_tick = !long_one;
    long_tick = long_one;
    wait_clk(1);
    {debounce_tick, long_tick} = 2'h0;
    wait_clk(10);
  endtask
  task summarize();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial
  begin
    {rst, input_good, holdoff_done, battery_low_cmp, charge_param_lock} = 5'h10;
    {debounce_tick, long_tick} = 2'h0;
    port_detect_result = 4'hE;
    wait_clk(10);
    rst = 1'b0;
    wait_clk(3);
    for (int i = 0; i < 14; i++)
    begin
      rd(ra[i]);
      chk("reset value", rv[i], rdat & (i == 13 ? 8'hF0 : 8'hFF));
    end
    for (int i = 0; i < 11; i++)
    begin
      wr(DEV_ADDR, wa[i], wd[i]);
      rd(wa[i]);
      chk("readback", we[i], rdat);
    end
    chk("recharge out", 8'hFF, rechg_out_r);
    chk("floor out", 8'h3F, sysfl_out_r);
    chk("window out", 8'hFF, ntcact_out_r);
    chk("threshold out", 8'h00, ntcth_out_r);
    port_detect_result = 4'h2;
    rd(ADDR_STAT0);
    chk("detect result", 8'h20, rdat);
    chk("restart pulses", 8'h01, 8'(n_rst));
    chk("test source", 8'h01, {7'h0, test_source_en_r});
    wr(7'h3E, 8'h04, 8'h00);
    chk("foreign nack", 8'h01, {7'h0, nack});
    rd(8'h04);
    chk("untouched", 8'hFF, rdat);
    wr(DEV_ADDR, 8'h0A, 8'h13);
    rd(8'h0A);
    chk("force self clear", 8'h03, rdat);
    input_good = 1'b1;
    wait_clk(10);
    wr(DEV_ADDR, 8'h0A, 8'h13);
    wait_clk(5);
    chk("forced detections", 8'h01, 8'(n_det));
    wr(DEV_ADDR, 8'h09, 8'h03);
    wr(DEV_ADDR, 8'h0A, 8'h00);
    wait_clk(5);
    chk("sink hiz", 8'h02, {6'h0, typec_sink_en_r, typec_hiz_r});
    wr(DEV_ADDR, 8'h0A, 8'h03);
    wait_clk(5);
    chk("sink hiz", 8'h01, {6'h0, typec_sink_en_r, typec_hiz_r});
    input_good = 1'b0;
    wr(DEV_ADDR, 8'h0A, 8'h23);
    input_good = 1'b1;
    holdoff_done = 1'b1;
    wait_clk(20);
    chk("auto detections", 8'h02, 8'(n_det));
    charge_param_lock = 1'b1;
    wr(DEV_ADDR, 8'h05, 8'h10);
    wr(DEV_ADDR, 8'h05, 8'h20);
    rd(8'h05);
    chk("locked code", 8'h10, rdat);
    charge_param_lock = 1'b0;
    wr(DEV_ADDR, 8'h09, 8'h07);
    battery_low_cmp = 1'b1;
    wait_clk(10);
    repeat (3) tick(1'b0);
    chk("low pulses", 8'h01, 8'(n_low));
    chk("boost latched", 8'h01, {7'h0, boost_lowbat_latched_r});
    battery_low_cmp = 1'b0;
    wr(DEV_ADDR, 8'h09, 8'h03);
    wait_clk(5);
    chk("latch cleared", 8'h00, {7'h0, boost_lowbat_latched_r});
    wr(DEV_ADDR, 8'h08, 8'h80);
    wait_clk(5);
    chk("switch now", 8'h01, {7'h0, battery_switch_open_r});
    wr(DEV_ADDR, 8'h08, 8'h40);
    wr(DEV_ADDR, 8'h08, 8'hC0);
    repeat (9) tick(1'b1);
    chk("switch at 9", 8'h00, {7'h0, battery_switch_open_r});
    tick(1'b1);
    chk("switch at 10", 8'h01, {7'h0, battery_switch_open_r});
    summarize();
  end
endmodule
